/* aod_output_demux.v */
// Behaviour
// - Late bus carries later sample, no delay
// - Early bus delayed one sample cycle
// - Early bus holds earlier sample of pair
// - Non-demux mode floats the early buses
// - Out-of-range when input exceeds half scale
// - Mirror clock copies data clock exactly
// - Both buses launched with data clock
// - Data clock half rate SDR, quarter DDR in demux mode
// - Data clock stopped during termination trim
// - Trim-skip bit omits later trims
// - Power-on calibration always trims once
// - Calibration-active high throughout calibration
// - Pin control overrides registers when high
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "aod_consts.vh"

module aod_output_demux #(
  parameter integer TRIM_CYC = `AOD_TRIM_CYC,
  parameter integer CORE_CYC = `AOD_CORE_CYC
) (
  input  wire                   mclk_i,               // System clock, 25 MHz
  input  wire                   rstn_i,               // Async reset, active low
  input  wire                   sample_clk_i,         // Sample clock, async
  input  wire [7:0]             i_sample_i,           // I converter word
  input  wire [7:0]             q_sample_i,           // Q converter word
  input  wire [10:0]            in_mag_mv_i,          // Input magnitude, mV
  input  wire                   cal_start_i,          // Calibration request pulse
  input  wire                   ext_control_enable_n_i, // High: pin control
  input  wire                   demux_pin_i,          // Pin: 1:2 demux select
  input  wire                   ddr_pin_i,            // Pin: DDR select
  input  wire                   mirror_pin_i,         // Pin: shared output is clock
  input  wire                   full_scale_setting_i, // Pin: full-scale select
  input  wire [`AOD_ADDR_W-1:0] reg_addr_i,           // Register index
  input  wire [15:0]            reg_wdata_i,          // Write data
  input  wire                   reg_wr_i,             // Write strobe
  input  wire                   reg_rd_i,             // Read strobe
  output reg  [15:0]            reg_rdata_o,          // Read data, next cycle
  output reg  [7:0]             i_chan_late_data_o,   // I later sample
  output reg  [7:0]             q_chan_late_data_o,   // Q later sample
  output reg  [7:0]             i_chan_early_data_o,  // I earlier sample
  output reg  [7:0]             q_chan_early_data_o,  // Q earlier sample
  output wire                   early_oe_n_o,         // Early bus enable, low drives
  output wire                   forwarded_data_clock_o, // Data clock
  output wire                   mirror_data_clock_o,  // Shared range flag / clock
  output wire                   calibration_active_o, // Calibration running
  output wire                   irq_o                 // Interrupt, level
);

  // One-hot calibration states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_TRIM = 3'b010;
  localparam [2:0] ST_CORE = 3'b100;

  // Register index decode, shared by the write paths
  function addr_hit;
    input [`AOD_ADDR_W-1:0] addr;
    input [`AOD_ADDR_W-1:0] idx;
    begin
      addr_hit = (addr == idx);
    end
  endfunction

  // Software-visible registers
  reg  [15:0] cfg_reg;
  reg  [1:0]  irq_stat_reg;
  reg  [1:0]  irq_mask_reg;

  // Calibration sequencer
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [15:0] cnt_reg;
  reg  [15:0] cnt_next;
  reg         por_cal_reg;
  reg         por_req_reg;

  // Synchronisers; stage pairs for the configuration pins
  reg  [2:0]  sclk_sync_reg;
  reg  [1:0]  pin_s1_reg;
  reg  [1:0]  pin_s2_reg;
  reg  [1:0]  pin_s3_reg;
  reg  [1:0]  pin_s4_reg;
  reg  [1:0]  pin_s5_reg;
  reg  [1:0]  pin_s6_reg;

  // Demultiplexer and data clock
  reg         phase_reg;
  reg         div_reg;
  reg         forwarded_data_clock_reg;
  reg         oor_reg;
  reg  [7:0]  i_hold_reg;
  reg  [7:0]  q_hold_reg;

  // Combinational helpers
  reg         cal_done;
  wire        sample_edge;

  // Effective configuration, from pins or register
  wire        pin_mode;
  wire        demux_en;
  wire        ddr_en;
  wire        mirror_en;
  wire        trim_skip;
  wire [10:0] fs_mv;
  wire        oor_now;
  wire        forwarded_data_clock_run;
  wire        forwarded_data_clock_step;
  wire [1:0]  irq_set;

  // Pins from outside the clock domain pass two flops first.
  // The sample clock gets a third stage so that its rising edge can be
  // found by comparing two settled copies; it therefore needs more than
  // one system-clock period high and more than one low.
  // Configuration pins take two cycles to act, so a pin change is not
  // seen by the output path before the third edge after it.
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_sync_reg <= 3'h0;
      pin_s1_reg    <= 2'h0;
      pin_s2_reg    <= 2'h0;
      pin_s3_reg    <= 2'h0;
      pin_s4_reg    <= 2'h0;
      pin_s5_reg    <= 2'h0;
      pin_s6_reg    <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sample_clk_i};
      pin_s1_reg    <= {ext_control_enable_n_i, demux_pin_i};
      pin_s2_reg    <= pin_s1_reg;
      pin_s3_reg    <= {ddr_pin_i, mirror_pin_i};
      pin_s4_reg    <= pin_s3_reg;
      // Spare bit of the last pair is tied low
      pin_s5_reg    <= {full_scale_setting_i, 1'b0};
      pin_s6_reg    <= pin_s5_reg;
    end
  end

  // Rising edge of the sample clock, seen two to three cycles late
  assign sample_edge = sclk_sync_reg[1] & ~sclk_sync_reg[2];

  assign pin_mode  = pin_s2_reg[1];
  assign demux_en  = pin_mode ? pin_s2_reg[0] : cfg_reg[`AOD_CFG_DEMUX];
  assign ddr_en    = pin_mode ? pin_s4_reg[1] : cfg_reg[`AOD_CFG_DDR];
  assign mirror_en = pin_mode ? pin_s4_reg[0] : cfg_reg[`AOD_CFG_MIRROR];
  // Pin-controlled parts can never skip the trim
  assign trim_skip = ~pin_mode & cfg_reg[`AOD_CFG_TRIM_SKIP];
  assign fs_mv     = pin_mode ? (pin_s6_reg[1] ? `AOD_FS_HI_MV : `AOD_FS_LO_MV)
                              : {1'b0, cfg_reg[`AOD_CFG_FS_MSB:`AOD_CFG_FS_LSB], 2'b00};

  // beyond half of full scale
  // Doubled magnitude against full scale avoids a halving that would
  // lose the lowest bit of an odd full-scale setting
  assign oor_now = ({1'b0, in_mag_mv_i} << 1) > {1'b0, fs_mv};

  // Calibration sequencer: idle, then termination trim, then core.
  // A start request while busy is dropped rather than queued; the
  // power-on request wins over a start request in the same cycle.
  // The trim phase is the only part that stops the data clock, so a
  // receiver that keeps running on this clock must set the skip bit.
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cal_done   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (por_req_reg || cal_start_i) begin
          cnt_next = 16'h0;
          if (por_req_reg || !trim_skip) begin
            state_next = ST_TRIM;
          end else begin
            state_next = ST_CORE;
          end
        end
      end
      ST_TRIM: begin
        if (cnt_reg == TRIM_CYC[15:0] - 16'h1) begin
          cnt_next   = 16'h0;
          state_next = ST_CORE;
        end else begin
          cnt_next = cnt_reg + 16'h1;
        end
      end
      ST_CORE: begin
        if (cnt_reg == CORE_CYC[15:0] - 16'h1) begin
          cnt_next   = 16'h0;
          state_next = ST_IDLE;
          cal_done   = 1'b1;
        end else begin
          cnt_next = cnt_reg + 16'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next   = 16'h0;
      end
    endcase
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 16'h0;
      por_cal_reg <= 1'b1;
      por_req_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      // Power-on calibration fires once, one cycle after reset release
      // A mid-run reset is treated as a new power-on and trims again
      por_cal_reg <= 1'b0;
      por_req_reg <= por_cal_reg;
    end
  end

  assign calibration_active_o = ~state_reg[0];

  assign forwarded_data_clock_run  = ~state_reg[1];
  // divide by sample edges
  // SDR and non-demux DDR toggle on every sample edge; demux DDR only when the divider is set
  assign forwarded_data_clock_step = sample_edge & forwarded_data_clock_run & (~(demux_en & ddr_en) | div_reg);

  // Output path: words change on the same mclk edge as the clock toggles,
  // so the receiver sees data and clock edge together.
  // In double data rate the divider bit and the pair phase toggle on the
  // same sample edges from reset, so each data update falls on a clock toggle until a pass through non-demux mode.
  // Leaving non-demux mode restarts the pairing with the next sample;
  // the divider keeps its phase, which may shift the first clock edge.
  // The early words keep their last value while the buses are floated;
  // only the enable tells the pads to release them.
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_reg           <= 1'b0;
      div_reg             <= 1'b0;
      forwarded_data_clock_reg            <= 1'b0;
      oor_reg             <= 1'b0;
      i_hold_reg          <= 8'h0;
      q_hold_reg          <= 8'h0;
      i_chan_late_data_o  <= 8'h0;
      q_chan_late_data_o  <= 8'h0;
      i_chan_early_data_o <= 8'h0;
      q_chan_early_data_o <= 8'h0;
    end else begin
      if (sample_edge) begin
        oor_reg <= oor_now;
        div_reg <= ~div_reg;
        if (!demux_en) begin
          i_chan_late_data_o <= i_sample_i;
          q_chan_late_data_o <= q_sample_i;
          phase_reg          <= 1'b0;
        end else if (!phase_reg) begin
          // first of pair waits a cycle
          i_hold_reg <= i_sample_i;
          q_hold_reg <= q_sample_i;
          phase_reg  <= 1'b1;
        end else begin
          i_chan_late_data_o  <= i_sample_i;
          q_chan_late_data_o  <= q_sample_i;
          i_chan_early_data_o <= i_hold_reg;
          q_chan_early_data_o <= q_hold_reg;
          phase_reg           <= 1'b0;
        end
      end
      if (forwarded_data_clock_step) begin
        forwarded_data_clock_reg <= ~forwarded_data_clock_reg;
      end
    end
  end

  // early buses float
  // Active-low enable, as the pads expect; low while the buses drive
  assign early_oe_n_o = ~demux_en;
  // Data clock straight from its flop, no gating on the pad path
  assign forwarded_data_clock_o = forwarded_data_clock_reg;
  assign mirror_data_clock_o = mirror_en ? forwarded_data_clock_reg : oor_reg;

  // Register file and sticky interrupts.
  // Reads answer one cycle after the strobe and show zero otherwise, so
  // a wired-or of several register blocks on one read bus stays possible.
  // Writes to unmapped indices are ignored and unused bits read zero.
  // Event sources: range flag per sample edge, calibration done
  assign irq_set = {sample_edge & oor_now, cal_done};

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg      <= `AOD_CFG_RESET;
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      reg_rdata_o  <= 16'h0;
    end else begin
      if (reg_wr_i && addr_hit(reg_addr_i, `AOD_REG_EXTCFG)) begin
        cfg_reg <= reg_wdata_i & `AOD_CFG_MASK;
      end
      if (reg_wr_i && addr_hit(reg_addr_i, `AOD_REG_IRQ_MASK)) begin
        irq_mask_reg <= reg_wdata_i[1:0];
      end
      // A new event wins over a write-one clear in the same cycle
      if (reg_wr_i && addr_hit(reg_addr_i, `AOD_REG_IRQ_STAT)) begin
        irq_stat_reg <= (irq_stat_reg & ~reg_wdata_i[1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      reg_rdata_o <= 16'h0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `AOD_REG_EXTCFG:   reg_rdata_o <= cfg_reg;
          `AOD_REG_IRQ_STAT: reg_rdata_o <= {14'h0, irq_stat_reg};
          `AOD_REG_IRQ_MASK: reg_rdata_o <= {14'h0, irq_mask_reg};
          // Read-only snapshot: pin mode, range flag, clock, demux, ddr, state
          `AOD_REG_STATE:    reg_rdata_o <= {8'h0,
                                             pin_mode,
                                             oor_reg,
                                             forwarded_data_clock_reg,
                                             demux_en,
                                             ddr_en,
                                             state_reg};
          default:           reg_rdata_o <= 16'h0;
        endcase
      end
    end
  end

  // Level interrupt: any status bit whose mask bit is set
  // Clearing the mask silences the line without losing the events
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

endmodule // aod_output_demux

`default_nettype wire

/* aod_consts.vh */
`ifndef AOD_CONSTS_VH
`define AOD_CONSTS_VH

// Register indices on the plain register port
`define AOD_ADDR_W         4
`define AOD_REG_EXTCFG     4'h9
`define AOD_REG_IRQ_STAT   4'ha
`define AOD_REG_IRQ_MASK   4'hb
`define AOD_REG_STATE      4'hc

// Extended configuration fields
`define AOD_CFG_DEMUX      0
`define AOD_CFG_DDR        1
`define AOD_CFG_MIRROR     2
`define AOD_CFG_TRIM_SKIP  3
`define AOD_CFG_FS_LSB     8
`define AOD_CFG_FS_MSB     15
`define AOD_CFG_MASK       16'hff0f
`define AOD_CFG_RESET      16'hc801

// Interrupt status / mask bits
`define AOD_IRQ_CAL_DONE   0
`define AOD_IRQ_OOR        1

// Full scale in millivolts for pin control (low / high setting)
`define AOD_FS_LO_MV       11'h258
`define AOD_FS_HI_MV       11'h320

// Calibration phase times
`define AOD_CLK_MHZ        25
`define AOD_TRIM_NS        2000
`define AOD_CORE_NS        8000
`define AOD_TRIM_CYC       ((`AOD_TRIM_NS * `AOD_CLK_MHZ + 999) / 1000)
`define AOD_CORE_CYC       ((`AOD_CORE_NS * `AOD_CLK_MHZ + 999) / 1000)

`endif

/* aod_output_demux_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module aod_output_demux_monitor #(
  parameter integer TRIM_CYC = 4,
  parameter integer CORE_CYC = 8
) (
  input wire        mclk_i, rstn_i, reg_wr_i, reg_rd_i, ext_control_enable_n_i,
  input wire        demux_pin_i, mirror_pin_i, early_oe_n_o, forwarded_data_clock_o,
  input wire        mirror_data_clock_o, calibration_active_o, irq_o,
  input wire [3:0]  reg_addr_i,
  input wire [15:0] reg_wdata_i, reg_rdata_o,
  input wire [7:0]  i_chan_late_data_o, i_chan_early_data_o
);
  reg [15:0] cnt_reg;
  reg        pon_reg;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Only the power-on run is sure to trim, later ones depend on config
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 16'h0;
      pon_reg <= 1'b1;
    end else begin
      cnt_reg <= calibration_active_o ? cnt_reg + 16'h1 : 16'h0;
      if (!calibration_active_o && cnt_reg != 16'h0) pon_reg <= 1'b0;
    end
  end
  a_rdata_idle_zero: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0) else $error("rdata not idle");
  a_early_bus_float: assert property (
    ext_control_enable_n_i && $past(ext_control_enable_n_i, 4) &&
    $past(demux_pin_i, 4) == demux_pin_i |-> early_oe_n_o == !demux_pin_i)
    else $error("early enable wrong");
  a_mirror_copy: assert property (
    ext_control_enable_n_i && $past(ext_control_enable_n_i, 4) && mirror_pin_i &&
    $past(mirror_pin_i, 4) |-> mirror_data_clock_o == forwarded_data_clock_o)
    else $error("mirror differs");
  a_trim_clock_frozen: assert property (
    pon_reg && calibration_active_o && cnt_reg != 16'h0 && cnt_reg < TRIM_CYC
    |-> $stable(forwarded_data_clock_o)) else $error("clock ran in trim");
  a_cal_length: assert property (
    $fell(calibration_active_o) |-> cnt_reg == TRIM_CYC + CORE_CYC || cnt_reg == CORE_CYC)
    else $error("calibration length");
  a_late_on_clock: assert property (
    !calibration_active_o && $changed(i_chan_late_data_o)
    |-> $changed(forwarded_data_clock_o)) else $error("late word off clock");
  a_early_enabled: assert property (
    $changed(i_chan_early_data_o) |-> $past(early_oe_n_o) == 1'b0)
    else $error("early word while off");
  a_irq_masked: assert property (
    $past(reg_wr_i) && $past(reg_addr_i) == 4'hb && $past(reg_wdata_i) == 16'h0
    |-> !irq_o) else $error("irq while masked");
endmodule // aod_output_demux_monitor
bind aod_output_demux aod_output_demux_monitor #(.TRIM_CYC(TRIM_CYC), .CORE_CYC(CORE_CYC))
  aod_output_demux_monitor_i (.*);
`default_nettype wire

/* aod_capture_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aod_capture_model (
  input  wire       mclk_i,      // Capture clock
  input  wire       forwarded_data_clock_i,      // Forwarded data clock
  input  wire       oe_n_i,      // Early bus released when high
  input  wire [7:0] late_i,      // Late word
  input  wire [7:0] early_i,     // Early word
  output reg  [7:0] cap_late_o,  // Captured late word
  output reg  [7:0] cap_early_o  // Captured early word
);
  reg forwarded_data_clock_q;
  // data clock only sampled, it pauses in the trim phase of calibration
  always @(posedge mclk_i) begin
    forwarded_data_clock_q <= forwarded_data_clock_i;
    if (forwarded_data_clock_q != forwarded_data_clock_i) begin
      cap_late_o  <= late_i;
      // released bus left floating, so no held value is seen
      cap_early_o <= oe_n_i ? ~cap_early_o : early_i;
    end
  end
endmodule // aod_capture_model
`default_nettype wire

/* aod_output_demux_test.sv */
`timescale 1ns/1ps
`default_nettype none
module aod_output_demux_test;
  reg         clk = 1'b0, rstn = 1'b0, sclk = 1'b0, cst = 1'b0, ext = 1'b0;
  reg         dpin = 1'b1, mpin = 1'b0, wr = 1'b0, rd = 1'b0;
  reg  [7:0]  smp = 8'h0, held;
  reg  [10:0] mag = 11'h0;
  reg  [3:0]  addr = 4'h0;
  reg  [15:0] wd = 16'h0;
  reg  [2:0]  ph = 3'h0;
  wire [15:0] rdata;
  wire [7:0]  il, ql, ie, qe, cl, ce;
  wire        oe_n, forwarded_data_clock, mir, cal, irq;
  integer     n_fail = 0, compares = 0, k;
  aod_output_demux #(.TRIM_CYC(4), .CORE_CYC(8)) aod_output_demux_i (
    .mclk_i(clk), .rstn_i(rstn), .sample_clk_i(sclk), .i_sample_i(smp), .q_sample_i(~smp),
    .in_mag_mv_i(mag), .cal_start_i(cst), .ext_control_enable_n_i(ext), .demux_pin_i(dpin),
    .ddr_pin_i(1'b0), .mirror_pin_i(mpin), .full_scale_setting_i(1'b1), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .i_chan_late_data_o(il), .q_chan_late_data_o(ql), .i_chan_early_data_o(ie),
    .q_chan_early_data_o(qe), .early_oe_n_o(oe_n), .forwarded_data_clock_o(forwarded_data_clock),
    .mirror_data_clock_o(mir), .calibration_active_o(cal), .irq_o(irq));
  aod_capture_model aod_capture_model_i (.mclk_i(clk), .forwarded_data_clock_i(forwarded_data_clock), .oe_n_i(oe_n),
    .late_i(il), .early_i(ie), .cap_late_o(cl), .cap_early_o(ce));
  initial forever #20 clk = ~clk;
  // Sample clock of 320 ns; words change mid-period, away from the capture edge
  always @(posedge clk) begin
    ph <= ph + 3'h1;
    if (ph == 3'h0) sclk <= 1'b1;
    if (ph == 3'h4) begin
      sclk <= 1'b0;
      smp <= smp + 8'h1;
    end
  end
  task check(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task reg_wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task reg_rd(input [3:0] a, input [15:0] exp);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
    end
  endtask
  task cal_len(input [15:0] exp);
    integer c;
    begin
      c = 0;
      for (k = 0; k < 40 && cal !== 1'b1; k = k + 1) @(posedge clk) #1;
      while (cal === 1'b1 && c < 100) begin
        @(posedge clk) #1;
        c = c + 1;
      end
      check(c, exp);
    end
  endtask
  task cal_run(input [15:0] exp);
    begin
      cst <= 1'b1;
      @(posedge clk);
      cst <= 1'b0;
      #1;
      cal_len(exp);
    end
  endtask
  task tog(input [15:0] exp);
    integer c;
    reg p;
    begin
      c = 0;
      p = forwarded_data_clock;
      repeat (256) begin
        @(posedge clk) #1;
        if (forwarded_data_clock !== p) c = c + 1;
        p = forwarded_data_clock;
      end
      check(c, exp);
    end
  endtask
  task finish_test;
    begin
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_fail = n_fail + 1;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cal_len(16'd12);
    reg_rd(4'h9, 16'hc801);
    reg_wr(4'h3, 16'hffff);
    reg_rd(4'h3, 16'h0);
    repeat (40) @(posedge clk);
    #1 check({8'h0, ie + 8'h1}, {8'h0, il});
    check({ql, qe}, {~il, ~ie});
    check({8'h0, ce + 8'h1}, {8'h0, cl});
    tog(16'd32);
    reg_wr(4'h9, 16'hc803);
    tog(16'd16);
    reg_wr(4'h9, 16'hc800);
    #1 check(oe_n, 1'b1);
    // The first non-demux update may still follow a finished pair, so start one later
    repeat (8) @(posedge clk);
    #1 held = il;
    repeat (8) @(posedge clk);
    #1 check({8'h0, il}, {8'h0, held + 8'h1});
    reg_wr(4'h9, 16'hc801);
    ext <= 1'b1;
    dpin <= 1'b0;
    mpin <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check({oe_n, mir}, {1'b1, forwarded_data_clock});
    ext <= 1'b0;
    dpin <= 1'b1;
    mpin <= 1'b0;
    reg_wr(4'h9, 16'hc805);
    repeat (4) @(posedge clk);
    #1 check(mir, forwarded_data_clock);
    reg_wr(4'h9, 16'hc809);
    cal_run(16'd8);
    reg_wr(4'h9, 16'hc801);
    cal_run(16'd12);
    reg_wr(4'hb, 16'h2);
    mag <= 11'h191;
    repeat (16) @(posedge clk);
    #1 check({mir, irq}, 2'b11);
    mag <= 11'h190;
    repeat (16) @(posedge clk);
    #1 check(mir, 1'b0);
    reg_wr(4'hb, 16'h0);
    #1 check(irq, 1'b0);
    reg_wr(4'ha, 16'h3);
    reg_rd(4'ha, 16'h0);
    reg_wr(4'h9, 16'hc809);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cal_len(16'd12);
    finish_test;
  end
endmodule // aod_output_demux_test
`default_nettype wire
